// File: logic/sbp_port.sv
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sbp_port
    import sbp_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [SBP_ADDR_W-1:0] ADDR,
    input wire logic MASTER_SELECT_N,
    input wire logic SELECT_HIGH,
    input wire logic SELECT_LOW_N,
    input wire logic PROC_ADDR_STROBE_N,
    input wire logic CTRL_ADDR_STROBE_N,
    input wire logic BURST_ADVANCE_N,
    input wire logic ALL_WRITE_N,
    input wire logic LANE_WRITE_ENABLE_N,
    input wire logic LANE0_WRITE_N,
    input wire logic LANE1_WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic BURST_ORDER_SEL,
    input wire logic SLEEP_REQ,
    input wire logic [SBP_DATA_W-1:0] DQ_I,
    output logic [SBP_DATA_W-1:0] DQ_O,
    output logic DQ_OE,
    output logic SLEEPING,
    output logic [SBP_ADDR_W-1:0] MEM_ADDR,
    output logic [SBP_LANES-1:0] MEM_WE,
    output logic [SBP_DATA_W-1:0] MEM_WDATA,
    input wire logic [SBP_DATA_W-1:0] MEM_RDATA
);

    sbp_port_s q;
    sbp_port_s d;
    sbp_ctrl_s ctl;
    logic [SBP_LANES-1:0] lanes;
    logic is_write;
    logic chip_on;
    logic proc_start;
    logic ctrl_start;
    logic load;
    logic step;
    logic [SBP_BURST_W-1:0] cur_lsb;
    logic [SBP_BURST_W-1:0] nxt_lsb;
    logic [SBP_ADDR_W-1:0] edge_addr;

    // ----------------------------------------
    // Synchronous pins gathered
    // ----------------------------------------
    assign ctl = {MASTER_SELECT_N, SELECT_HIGH, SELECT_LOW_N, PROC_ADDR_STROBE_N,
        CTRL_ADDR_STROBE_N, BURST_ADVANCE_N, ALL_WRITE_N, LANE_WRITE_ENABLE_N,
        LANE1_WRITE_N, LANE0_WRITE_N};

    // ----------------------------------------
    // Lane decode and burst counter
    // ----------------------------------------
    sbp_lane_dec sbp_lane_dec_inst (
        .all_write_n(ctl.all_write_n),
        .lane_write_enable_n(ctl.lane_write_enable_n),
        .lane_write_n(ctl.lane_write_n),
        .lanes(lanes)
    );

    assign is_write = |lanes;

    sbp_burst_ctr sbp_burst_ctr_inst (
        .clk(CLK),
        .srst(SRST),
        .load(load),
        .start_lsb(ADDR[SBP_BURST_W-1:0]),
        .step(step),
        .interleave(q.order),
        .cur_lsb(cur_lsb),
        .nxt_lsb(nxt_lsb)
    );

    // ----------------------------------------
    // Strobe and select decode
    // ----------------------------------------
    always_comb
    begin
        chip_on = !ctl.master_select_n && ctl.select_high && !ctl.select_low_n;
        proc_start = !ctl.proc_addr_strobe_n && !ctl.master_select_n;
        ctrl_start = !ctl.ctrl_addr_strobe_n && !proc_start;
        load = 1'b0;
        step = 1'b0;
        if (!q.sleep)
        begin
            if (proc_start || ctrl_start)
            begin
                load = chip_on;
            end
            else if (q.mode != SBP_DESELECT)
            begin
                step = !ctl.burst_advance_n;
            end
        end
    end

    always_comb
    begin
        if (load)
        begin
            edge_addr = ADDR;
        end
        else if (step)
        begin
            edge_addr = {q.addr_hi, nxt_lsb};
        end
        else
        begin
            edge_addr = {q.addr_hi, cur_lsb};
        end
    end

    // ----------------------------------------
    // Port state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.oe_meta = OUTPUT_ENABLE_N;
        d.oe_n = q.oe_meta;
        d.order_meta = BURST_ORDER_SEL;
        d.order = q.order_meta;
        d.sleep_meta = SLEEP_REQ;
        d.sleep = q.sleep_meta;
        if (q.sleep)
        begin
            d.mode = SBP_DESELECT;
        end
        else if (proc_start || ctrl_start)
        begin
            if (!chip_on)
            begin
                d.mode = SBP_DESELECT;
            end
            else if (proc_start)
            begin
                d.mode = SBP_READ;
            end
            else
            begin
                d.mode = is_write ? SBP_WRITE : SBP_READ;
            end
        end
        else if (q.mode != SBP_DESELECT)
        begin
            d.mode = is_write ? SBP_WRITE : SBP_READ;
        end
        if (load)
        begin
            d.addr_hi = ADDR[SBP_ADDR_W-1:SBP_BURST_W];
        end
        d.mem.addr = edge_addr;
        d.mem.we = (d.mode == SBP_WRITE) ? lanes : SBP_LANES_NONE;
        d.mem.wdata = DQ_I;
        d.rd_pend = (d.mode == SBP_READ);
        d.out_vld = q.rd_pend && !q.sleep && (d.mode != SBP_WRITE);
        d.dq_o = MEM_RDATA;
        if (SRST)
        begin
            d.oe_meta = SBP_OE_N_RST;
            d.oe_n = SBP_OE_N_RST;
            d.order_meta = SBP_ORDER_RST;
            d.order = SBP_ORDER_RST;
            d.sleep_meta = SBP_SLEEP_RST;
            d.sleep = SBP_SLEEP_RST;
            d.mode = SBP_DESELECT;
            d.addr_hi = '0;
            d.mem = '0;
            d.rd_pend = 1'b0;
            d.out_vld = 1'b0;
            d.dq_o = '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        q <= d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign DQ_OE = q.out_vld && !q.oe_n && !q.sleep;
    assign DQ_O = q.dq_o;
    assign SLEEPING = q.sleep;
    assign MEM_ADDR = q.mem.addr;
    assign MEM_WE = q.mem.we;
    assign MEM_WDATA = q.mem.wdata;

endmodule : sbp_port
`default_nettype wire

// File: logic/sbp_pkg.sv
package sbp_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned SBP_DATA_W = 18;
    localparam int unsigned SBP_LANES = 2;
    localparam int unsigned SBP_ADDR_W = 20;
    localparam int unsigned SBP_BURST_W = 2;
    localparam int unsigned SBP_HI_W = SBP_ADDR_W - SBP_BURST_W;

    // ----------------------------------------
    // Reset values and lane masks
    // ----------------------------------------
    localparam logic SBP_OE_N_RST = 1'h1;
    localparam logic SBP_ORDER_RST = 1'h1;
    localparam logic SBP_SLEEP_RST = 1'h0;
    localparam logic [SBP_BURST_W-1:0] SBP_COUNT_RST = 2'h0;
    localparam logic [SBP_LANES-1:0] SBP_LANES_ALL = 2'h3;
    localparam logic [SBP_LANES-1:0] SBP_LANES_NONE = 2'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {SBP_DESELECT, SBP_READ, SBP_WRITE} sbp_mode_e;

    typedef struct packed {
        logic master_select_n;
        logic select_high;
        logic select_low_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic all_write_n;
        logic lane_write_enable_n;
        logic [SBP_LANES-1:0] lane_write_n;
    } sbp_ctrl_s;

    typedef struct packed {
        logic [SBP_ADDR_W-1:0] addr;
        logic [SBP_LANES-1:0] we;
        logic [SBP_DATA_W-1:0] wdata;
    } sbp_mem_s;

    typedef struct packed {
        logic oe_meta;
        logic oe_n;
        logic order_meta;
        logic order;
        logic sleep_meta;
        logic sleep;
        sbp_mode_e mode;
        logic [SBP_HI_W-1:0] addr_hi;
        sbp_mem_s mem;
        logic rd_pend;
        logic out_vld;
        logic [SBP_DATA_W-1:0] dq_o;
    } sbp_port_s;

    typedef struct packed {
        logic [SBP_BURST_W-1:0] start;
        logic [SBP_BURST_W-1:0] count;
    } sbp_burst_s;

    // ----------------------------------------
    // Burst address arithmetic
    // ----------------------------------------
    function automatic logic [SBP_BURST_W-1:0] sbp_burst_lsb(
        input logic [SBP_BURST_W-1:0] start,
        input logic [SBP_BURST_W-1:0] count,
        input logic interleave
    );
        if (interleave)
        begin
            return start ^ count;
        end
        return SBP_BURST_W'(start + count);
    endfunction : sbp_burst_lsb

endpackage : sbp_pkg

// File: logic/sbp_lane_dec.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_lane_dec
    import sbp_pkg::*;
(
    input wire logic all_write_n,
    input wire logic lane_write_enable_n,
    input wire logic [SBP_LANES-1:0] lane_write_n,
    output logic [SBP_LANES-1:0] lanes
);

    // ----------------------------------------
    // Byte lane write decode
    // ----------------------------------------
    always_comb
    begin
        if (!all_write_n)
        begin
            lanes = SBP_LANES_ALL;
        end
        else if (!lane_write_enable_n)
        begin
            lanes = ~lane_write_n;
        end
        else
        begin
            lanes = SBP_LANES_NONE;
        end
    end

endmodule : sbp_lane_dec
`default_nettype wire

// File: logic/sbp_burst_ctr.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_burst_ctr
    import sbp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [SBP_BURST_W-1:0] start_lsb,
    input wire logic step,
    input wire logic interleave,
    output logic [SBP_BURST_W-1:0] cur_lsb,
    output logic [SBP_BURST_W-1:0] nxt_lsb
);

    sbp_burst_s q;
    sbp_burst_s d;

    // ----------------------------------------
    // Current and next burst address
    // ----------------------------------------
    assign cur_lsb = sbp_burst_lsb(q.start, q.count, interleave);
    assign nxt_lsb = sbp_burst_lsb(q.start, SBP_BURST_W'(q.count + 1'b1), interleave);

    // ----------------------------------------
    // Counter state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        if (srst)
        begin
            d.start = SBP_COUNT_RST;
            d.count = SBP_COUNT_RST;
        end
        else if (load)
        begin
            d.start = start_lsb;
            d.count = SBP_COUNT_RST;
        end
        else if (step)
        begin
            d.count = SBP_BURST_W'(q.count + 1'b1);
        end
    end

    always_ff @(posedge clk)
    begin
        q <= d;
    end

endmodule : sbp_burst_ctr
`default_nettype wire

// File: verif/sbp_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_port_props
    import sbp_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [SBP_ADDR_W-1:0] ADDR,
    input wire logic MASTER_SELECT_N,
    input wire logic SELECT_HIGH,
    input wire logic SELECT_LOW_N,
    input wire logic PROC_ADDR_STROBE_N,
    input wire logic CTRL_ADDR_STROBE_N,
    input wire logic BURST_ADVANCE_N,
    input wire logic ALL_WRITE_N,
    input wire logic LANE_WRITE_ENABLE_N,
    input wire logic LANE0_WRITE_N,
    input wire logic LANE1_WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQ,
    input wire logic [SBP_DATA_W-1:0] DQ_I,
    input wire logic [SBP_DATA_W-1:0] DQ_O,
    input wire logic DQ_OE,
    input wire logic SLEEPING,
    input wire logic [SBP_ADDR_W-1:0] MEM_ADDR,
    input wire logic [SBP_LANES-1:0] MEM_WE,
    input wire logic [SBP_DATA_W-1:0] MEM_WDATA,
    input wire logic [SBP_DATA_W-1:0] MEM_RDATA
);
    // ----
    // Checks
    // ----
    wire logic sel = !MASTER_SELECT_N && SELECT_HIGH && !SELECT_LOW_N;
    wire logic cst = !CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && !SLEEPING;
    wire logic pst = !PROC_ADDR_STROBE_N && !MASTER_SELECT_N && !SLEEPING;
    wire logic [1:0] ln = {LANE1_WRITE_N, LANE0_WRITE_N};
    wire logic oe3 = !OUTPUT_ENABLE_N;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_all;
        cst && sel && !ALL_WRITE_N |=> MEM_WE == SBP_LANES_ALL
            && MEM_ADDR == $past(ADDR) && MEM_WDATA == $past(DQ_I);
    endproperty
    a_all: assert property (p_all) else $error("full write");
    property p_lane;
        cst && sel && ALL_WRITE_N && !LANE_WRITE_ENABLE_N |=> MEM_WE == ~$past(ln);
    endproperty
    a_lane: assert property (p_lane) else $error("lane write");
    property p_bwe;
        cst && sel && ALL_WRITE_N && LANE_WRITE_ENABLE_N |=> MEM_WE == 2'h0;
    endproperty
    a_bwe: assert property (p_bwe) else $error("lane enable");
    property p_proc;
        pst && sel |=> MEM_WE == 2'h0 && MEM_ADDR == $past(ADDR);
    endproperty
    a_proc: assert property (p_proc) else $error("proc load");
    property p_desel;
        (cst || pst) && !sel |=> MEM_WE == 2'h0 ##1 !DQ_OE;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect");
    property p_block;
        !PROC_ADDR_STROBE_N && MASTER_SELECT_N && CTRL_ADDR_STROBE_N
            && BURST_ADVANCE_N && !SLEEPING |=> $stable(MEM_ADDR);
    endproperty
    a_block: assert property (p_block) else $error("proc not blocked");
    property p_read;
        pst && sel && oe3 && $past(oe3) && $past(oe3, 2)
            |-> ##2 DQ_OE && DQ_O == $past(MEM_RDATA);
    endproperty
    a_read: assert property (p_read) else $error("read drive");
    property p_burst;
        MEM_WE != 2'h0 && CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && !BURST_ADVANCE_N
            && !ALL_WRITE_N && !SLEEPING |=> MEM_WE == SBP_LANES_ALL
            && MEM_ADDR[19:2] == $past(MEM_ADDR[19:2]) && MEM_ADDR[1:0] != $past(MEM_ADDR[1:0]);
    endproperty
    a_burst: assert property (p_burst) else $error("burst step");
    property p_zin;
        SLEEP_REQ [*4] |-> SLEEPING;
    endproperty
    a_zin: assert property (p_zin) else $error("sleep entry");
    property p_zout;
        SLEEPING |-> !DQ_OE && MEM_WE == 2'h0;
    endproperty
    a_zout: assert property (p_zout) else $error("sleep outputs");
    c_wr: cover property (cst && sel && !ALL_WRITE_N);
    c_rd: cover property (pst && sel ##2 DQ_OE);
    c_zz: cover property (SLEEPING);
endmodule : sbp_port_props
`default_nettype wire

// File: verif/sbp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_mem_model
    import sbp_pkg::*;
(
    input wire logic clk,
    input wire logic [SBP_ADDR_W-1:0] addr,
    input wire logic [SBP_LANES-1:0] we,
    input wire logic [SBP_DATA_W-1:0] wdata,
    output logic [SBP_DATA_W-1:0] rdata
);
    // ----
    // Array
    // ----
    logic [SBP_DATA_W-1:0] mem [0:(1<<SBP_ADDR_W)-1];
    assign rdata = mem[addr];
    always @(posedge clk)
    begin
        if (we[0]) mem[addr][8:0] <= wdata[8:0];
        if (we[1]) mem[addr][17:9] <= wdata[17:9];
    end
endmodule : sbp_mem_model
`default_nettype wire

// File: verif/sbp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_port_bench
    import sbp_pkg::*;
;
    // ----
    // Bench
    // ----
    localparam logic [9:0] DES = 10'h05F, CWR = 10'h157, CONW = 10'h167, PRD = 10'h127;
    localparam logic [9:0] CONR = 10'h16F, CLN = 10'h158, CBWE = 10'h15F;
    localparam logic [9:0] BLK = 10'h337, PDES = 10'h1BF, SUS = 10'h17F;
    logic clk = 1'h0;
    logic srst = 1'h1;
    sbp_ctrl_s c = 10'h17F;
    logic [19:0] addr = 20'h0, maddr, la;
    logic [17:0] dqi = 18'h0, dq_o, rdata, wdata;
    logic oe_n = 1'h1, ord = 1'h1, slp = 1'h0, dq_oe, sleeping;
    logic [1:0] we;
    logic [17:0] sh [logic [19:0]];
    logic [39:0] wq [$], rq [$], e;
    int miscompares = 0, n_compared = 0;
    sbp_port sbp_port_inst (.CLK(clk), .SRST(srst), .ADDR(addr),
        .MASTER_SELECT_N(c.master_select_n), .SELECT_HIGH(c.select_high),
        .SELECT_LOW_N(c.select_low_n), .PROC_ADDR_STROBE_N(c.proc_addr_strobe_n),
        .CTRL_ADDR_STROBE_N(c.ctrl_addr_strobe_n), .BURST_ADVANCE_N(c.burst_advance_n),
        .ALL_WRITE_N(c.all_write_n), .LANE_WRITE_ENABLE_N(c.lane_write_enable_n),
        .LANE0_WRITE_N(c.lane_write_n[0]), .LANE1_WRITE_N(c.lane_write_n[1]),
        .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_SEL(ord), .SLEEP_REQ(slp), .DQ_I(dqi),
        .DQ_O(dq_o), .DQ_OE(dq_oe), .SLEEPING(sleeping), .MEM_ADDR(maddr), .MEM_WE(we),
        .MEM_WDATA(wdata), .MEM_RDATA(rdata));
    sbp_mem_model sbp_mem_model_inst (.clk(clk), .addr(maddr), .we(we), .wdata(wdata),
        .rdata(rdata));
    always #12.5 clk = ~clk;
    task automatic chk(input string n, input logic [39:0] x, input logic [39:0] g);
        n_compared++;
        if (x !== g)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask : chk
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic op(input logic [9:0] v, input logic [19:0] a, input logic [17:0] d);
        @(posedge clk);
        c <= v;
        addr <= a;
        dqi <= d;
    endtask : op
    task automatic set_oe(input logic v);
        oe_n <= v;
        repeat (3) @(posedge clk);
    endtask : set_oe
    function automatic logic [19:0] nx(input logic [19:0] a, input int k, input logic o);
        return {a[19:2], o ? a[1:0] ^ 2'(k) : 2'(a[1:0] + k)};
    endfunction : nx
    task automatic burst(input logic o);
        logic [19:0] a;
        logic [17:0] d;
        a = 20'($urandom);
        ord <= o;
        set_oe(1'h1);
        for (int k = 0; k < 4; k++)
        begin
            d = 18'($urandom);
            sh[nx(a, k, o)] = d;
            wq.push_back({nx(a, k, o), 2'h3, d});
            op(k == 0 ? CWR : CONW, a, d);
        end
        op(DES, a, 18'h0);
        set_oe(1'h0);
        for (int k = 0; k < 5; k++)
        begin
            rq.push_back({22'h0, sh[nx(a, k - int'(k > 1), o)]});
            op(k == 0 ? PRD : (k == 2 ? SUS : CONR), a, 18'h0);
        end
        op(DES, a, 18'h0);
        la = a;
    endtask : burst
    task automatic lanes;
        logic [19:0] a;
        logic [17:0] d;
        a = 20'($urandom);
        d = 18'($urandom);
        set_oe(1'h1);
        sh[a] = d;
        wq.push_back({a, 2'h3, d});
        op(CWR, a, d);
        for (int l = 3; l >= 0; l--)
        begin
            d = 18'($urandom);
            if (l[0]) sh[a][8:0] = d[8:0];
            if (l[1]) sh[a][17:9] = d[17:9];
            if (l != 0) wq.push_back({a, 2'(l), d});
            op(CLN | 10'(~l & 3), a, d);
        end
        op(CBWE, a, d);
        op(DES, a, d);
        set_oe(1'h0);
        rq.push_back({22'h0, sh[a]});
        op(CBWE, a, 18'h0);
        op(DES, a, 18'h0);
    endtask : lanes
    always @(negedge clk)
    begin
        if (!srst && we !== 2'h0)
        begin
            e = wq.size() != 0 ? wq.pop_front() : 'x;
            chk("write", e, {maddr, we, wdata});
        end
        if (!srst && dq_oe !== 1'h0)
        begin
            e = rq.size() != 0 ? rq.pop_front() : 'x;
            chk("read", e, {22'h0, dq_o});
        end
    end
    initial
    begin
        // Tests need well under 500 cycles
        repeat (4000) @(posedge clk);
        miscompares++;
        stop_test;
    end
    initial
    begin
        void'($urandom(32'h21B0));
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        repeat (2) @(posedge clk);
        burst(1'h1);
        burst(1'h0);
        $display("test burst done");
        lanes;
        $display("test lanes done");
        op(BLK, 20'($urandom), 18'h0);
        op(PDES, 20'h0, 18'h0);
        op(DES, 20'h0, 18'h0);
        repeat (4) @(posedge clk);
        $display("test select done");
        slp <= 1'h1;
        repeat (6) @(posedge clk);
        #1 chk("sleeping", 40'h1, 40'(sleeping));
        op(CWR, la, 18'h0);
        op(PRD, la, 18'h0);
        op(DES, la, 18'h0);
        slp <= 1'h0;
        repeat (4) @(posedge clk);
        rq.push_back({22'h0, sh[la]});
        op(PRD, la, 18'h0);
        op(DES, la, 18'h0);
        repeat (6) @(posedge clk);
        $display("test sleep done");
        chk("pending", 40'h0, 40'(wq.size() + rq.size()));
        stop_test;
    end
endmodule : sbp_port_bench
bind sbp_port sbp_port_props sbp_port_props_inst (.*);
`default_nettype wire
